// [hdl/pcg_pkg.sv]
// Constants, register map and state types for the peripheral bus clock gating block
package pcg_pkg;

	// Bus geometry
	localparam int unsigned PCG_ADDR_W = 4;
	localparam int unsigned PCG_DATA_W = 32;
	localparam int unsigned PCG_BE_W = 4;
	localparam int unsigned PCG_GATE_W = 8;
	localparam int unsigned PCG_GATE_N = 16;

	// Byte offsets of the registers
	localparam logic [PCG_ADDR_W-1:0] PCG_OFS_FIRST = 4'h0;
	localparam logic [PCG_ADDR_W-1:0] PCG_OFS_SECOND = 4'h4;
	localparam logic [PCG_ADDR_W-1:0] PCG_OFS_STATUS = 4'h8;

	// Reset values: every peripheral clocked until software says otherwise
	localparam logic [PCG_GATE_W-1:0] PCG_RST_FIRST = 8'hff;
	localparam logic [PCG_GATE_W-1:0] PCG_RST_SECOND = 8'hff;
	localparam logic PCG_RST_CELL = 1'h1;

	// Byte lane that carries the 8-bit registers
	localparam int unsigned PCG_BE_LOW = 0;

	// Bit positions in the first gating register
	localparam int unsigned PCG_BIT_CARRIER = 7;
	localparam int unsigned PCG_BIT_TIMER_TWO = 6;
	localparam int unsigned PCG_BIT_TIMER_ONE = 5;
	localparam int unsigned PCG_BIT_ADC = 4;
	localparam int unsigned PCG_BIT_DAC = 3;
	localparam int unsigned PCG_BIT_TWO_WIRE = 2;
	localparam int unsigned PCG_BIT_SERIAL_TWO = 1;
	localparam int unsigned PCG_BIT_SERIAL_ONE = 0;

	// Bit positions in the second gating register
	localparam int unsigned PCG_BIT_USB = 7;
	localparam int unsigned PCG_BIT_DELAY = 6;
	localparam int unsigned PCG_BIT_IRQ_PIN = 5;
	localparam int unsigned PCG_BIT_KEYBOARD = 4;
	localparam int unsigned PCG_BIT_COMPARATOR = 3;
	localparam int unsigned PCG_BIT_TIME_OF_DAY = 2;
	localparam int unsigned PCG_BIT_PSERIAL_TWO = 1;
	localparam int unsigned PCG_BIT_PSERIAL_ONE = 0;

	// Avalon-MM response codes
	localparam logic [1:0] PCG_RESP_OKAY = 2'h0;
	localparam logic [1:0] PCG_RESP_SLVERR = 2'h2;

	// Bus slave states
	typedef enum logic [0:0] {
		PCG_IDLE,
		PCG_ANSWER
	} pcg_bus_state_t;

	// Whole state of the top module
	typedef struct packed {
		pcg_bus_state_t state;
		logic [PCG_GATE_W-1:0] gate_first;
		logic [PCG_GATE_W-1:0] gate_second;
		logic [PCG_DATA_W-1:0] rdata;
		logic [1:0] resp;
	} pcg_regs_t;

	// Whole state of one gate cell
	typedef struct packed {
		logic on;
	} pcg_cell_t;

endpackage

// [hdl/pcg_gate_cell.sv]
// One glitch-free bus clock enable, retimed onto the bus clock edge
`timescale 1ns/1ps
module pcg_gate_cell (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic enable_i,
	output logic clk_en_o
);
	import pcg_pkg::*;

	pcg_cell_t cur;
	pcg_cell_t next_cur;

	// Enable follows the register one edge later, so it never changes mid-cycle
	always_comb begin
		next_cur = cur;
		next_cur.on = enable_i; // R18
	end

	// Reset opens the gate so every peripheral is clocked out of reset
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cur.on <= PCG_RST_CELL; // R17
		end else begin
			cur <= next_cur;
		end
	end

	assign clk_en_o = cur.on;

	// Enable changes only one edge after its control bit
	a_cell_retime: assert property (@(posedge clk_i) disable iff (srst_i) // R18
		!$past(srst_i) |-> clk_en_o == $past(enable_i))
		else $error("gate enable did not follow its control bit");

endmodule // pcg_gate_cell

// [hdl/pcg_clock_gating.sv]
// Peripheral bus clock gating: two gating registers on an Avalon-MM slave
// Function
// [R1] First register bit 7 clocks the carrier modulator when set, stops it when clear.
// [R2] First register bit 6 clocks the second timer when set, stops it when clear.
// [R3] First register bit 5 clocks the first timer when set, stops it when clear.
// [R4] First register bit 4 clocks the ADC when set, stops it when clear.
// [R5] First register bit 3 clocks the DAC when set, stops it when clear.
// [R6] First register bit 2 clocks the two-wire controller when set.
// [R7] First register bit 1 clocks the second async serial port when set.
// [R8] First register bit 0 clocks the first async serial port when set.
// [R9] Second register bit 7 clocks the USB module when set.
// [R10] Second register bit 6 clocks the delay block registers when set.
// [R11] Second register bit 5 clocks the external interrupt pin logic when set.
// [R12] Second register bit 4 clocks both keyboard interrupt modules together.
// [R13] Second register bit 3 clocks both comparators together.
// [R14] Second register bit 2 gates only the time-of-day bus clock, not its timebase.
// [R15] Second register bit 1 clocks the second SPI port when set.
// [R16] Second register bit 0 clocks the first SPI port when set.
// [R17] Both gating registers reset to all ones.
// [R18] Registers read back last write; gating changes glitch-free on clock edges.
`timescale 1ns/1ps
module pcg_clock_gating (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [pcg_pkg::PCG_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [pcg_pkg::PCG_DATA_W-1:0] avs_writedata_i,
	input wire logic [pcg_pkg::PCG_BE_W-1:0] avs_byteenable_i,
	output logic [pcg_pkg::PCG_DATA_W-1:0] avs_readdata_o,
	output logic [1:0] avs_response_o,
	output logic avs_waitrequest_o,
	output logic carrier_modulator_gate_o,
	output logic timer_two_gate_o,
	output logic timer_one_gate_o,
	output logic adc_gate_o,
	output logic dac_gate_o,
	output logic two_wire_bus_gate_o,
	output logic serial_port_two_gate_o,
	output logic serial_port_one_gate_o,
	output logic usb_gate_o,
	output logic delay_block_gate_o,
	output logic irq_pin_gate_o,
	output logic keyboard_interrupt_gate_o,
	output logic comparator_gate_o,
	output logic time_of_day_gate_o,
	output logic peripheral_serial_two_gate_o,
	output logic peripheral_serial_one_gate_o
);
	import pcg_pkg::*;

	pcg_regs_t cur;
	pcg_regs_t next_cur;
	logic [PCG_GATE_N-1:0] gate_ctrl;
	wire logic [PCG_GATE_N-1:0] gate_on;
	logic request;
	logic mapped;
	logic [PCG_DATA_W-1:0] read_mux;

	// Address decode and read selection
	assign request = avs_read_i || avs_write_i;
	assign mapped = (avs_address_i == PCG_OFS_FIRST) || (avs_address_i == PCG_OFS_SECOND)
		|| (avs_address_i == PCG_OFS_STATUS);

	// Status shows the enables the peripherals really see, one edge behind the control
	always_comb begin
		read_mux = '0;
		if (avs_address_i == PCG_OFS_FIRST) begin
			read_mux[PCG_GATE_W-1:0] = cur.gate_first; // R18
		end else if (avs_address_i == PCG_OFS_SECOND) begin
			read_mux[PCG_GATE_W-1:0] = cur.gate_second; // R18
		end else if (avs_address_i == PCG_OFS_STATUS) begin
			read_mux[PCG_GATE_N-1:0] = gate_on;
		end
	end

	// Bus slave: one wait cycle, answer on the second edge, writes land there too
	always_comb begin
		next_cur = cur;
		unique case (cur.state)
			PCG_IDLE: begin
				if (request) begin
					next_cur.state = PCG_ANSWER;
					next_cur.resp = mapped ? PCG_RESP_OKAY : PCG_RESP_SLVERR;
					next_cur.rdata = avs_read_i ? read_mux : '0;
				end
			end
			PCG_ANSWER: begin
				next_cur.state = PCG_IDLE;
				// Only the low lane holds data; writes without it are ignored
				if (avs_write_i && avs_byteenable_i[PCG_BE_LOW]) begin
					if (avs_address_i == PCG_OFS_FIRST) begin
						next_cur.gate_first = avs_writedata_i[PCG_GATE_W-1:0]; // R18
					end else if (avs_address_i == PCG_OFS_SECOND) begin
						next_cur.gate_second = avs_writedata_i[PCG_GATE_W-1:0]; // R18
					end
				end
			end
		endcase
	end

	// State register; gating registers come up all ones
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cur.state <= PCG_IDLE;
			cur.gate_first <= PCG_RST_FIRST; // R17
			cur.gate_second <= PCG_RST_SECOND; // R17
			cur.rdata <= '0;
			cur.resp <= PCG_RESP_OKAY;
		end else begin
			cur <= next_cur;
		end
	end

	// Handshake outputs
	assign avs_waitrequest_o = request && (cur.state != PCG_ANSWER);
	assign avs_readdata_o = cur.rdata;
	assign avs_response_o = cur.resp;

	// One retimed enable per control bit; a flop never glitches, unlike a gate on clk
	assign gate_ctrl = {cur.gate_second, cur.gate_first};
	for (genvar g = 0; g < PCG_GATE_N; g++) begin : g_cell
		pcg_gate_cell u_cell (
			.clk_i(clk_i),
			.srst_i(srst_i),
			.enable_i(gate_ctrl[g]),
			.clk_en_o(gate_on[g])
		);
	end

	// First register bits to peripheral enables
	assign carrier_modulator_gate_o = gate_on[PCG_BIT_CARRIER]; // R1
	assign timer_two_gate_o = gate_on[PCG_BIT_TIMER_TWO]; // R2
	assign timer_one_gate_o = gate_on[PCG_BIT_TIMER_ONE]; // R3
	assign adc_gate_o = gate_on[PCG_BIT_ADC]; // R4
	assign dac_gate_o = gate_on[PCG_BIT_DAC]; // R5
	assign two_wire_bus_gate_o = gate_on[PCG_BIT_TWO_WIRE]; // R6
	assign serial_port_two_gate_o = gate_on[PCG_BIT_SERIAL_TWO]; // R7
	assign serial_port_one_gate_o = gate_on[PCG_BIT_SERIAL_ONE]; // R8

	// Second register bits; keyboard and comparator pairs share one enable each
	assign usb_gate_o = gate_on[PCG_GATE_W + PCG_BIT_USB]; // R9
	assign delay_block_gate_o = gate_on[PCG_GATE_W + PCG_BIT_DELAY]; // R10
	assign irq_pin_gate_o = gate_on[PCG_GATE_W + PCG_BIT_IRQ_PIN]; // R11
	assign keyboard_interrupt_gate_o = gate_on[PCG_GATE_W + PCG_BIT_KEYBOARD]; // R12
	assign comparator_gate_o = gate_on[PCG_GATE_W + PCG_BIT_COMPARATOR]; // R13
	// Bus side only: the time-of-day timebase is not touched here
	assign time_of_day_gate_o = gate_on[PCG_GATE_W + PCG_BIT_TIME_OF_DAY]; // R14
	assign peripheral_serial_two_gate_o = gate_on[PCG_GATE_W + PCG_BIT_PSERIAL_TWO]; // R15
	assign peripheral_serial_one_gate_o = gate_on[PCG_GATE_W + PCG_BIT_PSERIAL_ONE]; // R16

	// Checks on the register-to-enable path and the bus; the !$past(srst_i) checks skip the edge right after reset
	a_carrier_bit: assert property (@(posedge clk_i) disable iff (srst_i) // R1
		!$past(srst_i) |-> carrier_modulator_gate_o == $past(cur.gate_first[PCG_BIT_CARRIER]))
		else $error("carrier modulator enable wrong");
	a_timer_two_bit: assert property (@(posedge clk_i) disable iff (srst_i) // R2
		$fell(cur.gate_first[PCG_BIT_TIMER_TWO]) |=> !timer_two_gate_o)
		else $error("second timer enable not cleared");
	a_timer_one_bit: assert property (@(posedge clk_i) disable iff (srst_i) // R3
		$rose(cur.gate_first[PCG_BIT_TIMER_ONE]) |-> !timer_one_gate_o ##1 timer_one_gate_o)
		else $error("first timer enable not set one edge later");
	a_adc_bit: assert property (@(posedge clk_i) disable iff (srst_i) // R4
		!$past(srst_i) |-> adc_gate_o == $past(cur.gate_first[PCG_BIT_ADC]))
		else $error("analog input converter enable wrong");
	a_dac_bit: assert property (@(posedge clk_i) disable iff (srst_i) // R5
		!$past(srst_i) |-> dac_gate_o == $past(cur.gate_first[PCG_BIT_DAC]))
		else $error("analog output converter enable wrong");
	a_two_wire_bit: assert property (@(posedge clk_i) disable iff (srst_i) // R6
		!$past(srst_i) |-> two_wire_bus_gate_o == $past(cur.gate_first[PCG_BIT_TWO_WIRE]))
		else $error("two-wire controller enable wrong");
	a_serial_two_bit: assert property (@(posedge clk_i) disable iff (srst_i) // R7
		!$past(srst_i) |->
		serial_port_two_gate_o == $past(cur.gate_first[PCG_BIT_SERIAL_TWO]))
		else $error("second async serial enable wrong");
	a_serial_one_bit: assert property (@(posedge clk_i) disable iff (srst_i) // R8
		!$past(srst_i) |->
		serial_port_one_gate_o == $past(cur.gate_first[PCG_BIT_SERIAL_ONE]))
		else $error("first async serial enable wrong");
	a_usb_bit: assert property (@(posedge clk_i) disable iff (srst_i) // R9
		!$past(srst_i) |-> usb_gate_o == $past(cur.gate_second[PCG_BIT_USB]))
		else $error("usb enable wrong");
	a_delay_bit: assert property (@(posedge clk_i) disable iff (srst_i) // R10
		!$past(srst_i) |-> delay_block_gate_o == $past(cur.gate_second[PCG_BIT_DELAY]))
		else $error("delay block enable wrong");
	a_irq_pin_bit: assert property (@(posedge clk_i) disable iff (srst_i) // R11
		!$past(srst_i) |-> irq_pin_gate_o == $past(cur.gate_second[PCG_BIT_IRQ_PIN]))
		else $error("interrupt pin enable wrong");
	a_keyboard_bit: assert property (@(posedge clk_i) disable iff (srst_i) // R12
		!$past(srst_i) |->
		keyboard_interrupt_gate_o == $past(cur.gate_second[PCG_BIT_KEYBOARD]))
		else $error("keyboard enable wrong");
	a_comparator_bit: assert property (@(posedge clk_i) disable iff (srst_i) // R13
		!$past(srst_i) |-> comparator_gate_o == $past(cur.gate_second[PCG_BIT_COMPARATOR]))
		else $error("comparator enable wrong");
	a_time_of_day_bit: assert property (@(posedge clk_i) disable iff (srst_i) // R14
		!$past(srst_i) |->
		time_of_day_gate_o == $past(cur.gate_second[PCG_BIT_TIME_OF_DAY]))
		else $error("time-of-day enable wrong");
	a_spi_two_bit: assert property (@(posedge clk_i) disable iff (srst_i) // R15
		!$past(srst_i) |->
		peripheral_serial_two_gate_o == $past(cur.gate_second[PCG_BIT_PSERIAL_TWO]))
		else $error("second SPI enable wrong");
	a_spi_one_bit: assert property (@(posedge clk_i) disable iff (srst_i) // R16
		cur.state == PCG_ANSWER && avs_write_i && avs_byteenable_i[PCG_BE_LOW]
		&& avs_address_i == PCG_OFS_SECOND |=> ##1
		peripheral_serial_one_gate_o == $past(avs_writedata_i[PCG_BIT_PSERIAL_ONE], 2))
		else $error("first SPI enable did not follow the write");
	a_reset_ones: assert property (@(posedge clk_i) // R17
		srst_i |=> cur.gate_first == PCG_RST_FIRST && cur.gate_second == PCG_RST_SECOND
		&& gate_on == {PCG_RST_SECOND, PCG_RST_FIRST})
		else $error("gating not all ones after reset");
	a_write_lands: assert property (@(posedge clk_i) disable iff (srst_i) // R18
		cur.state == PCG_ANSWER && avs_write_i && avs_byteenable_i[PCG_BE_LOW]
		&& avs_address_i == PCG_OFS_FIRST
		|=> cur.gate_first == $past(avs_writedata_i[PCG_GATE_W-1:0]))
		else $error("write to first gating register lost");
	// Writes without the low lane, or to status or a hole, must not move the gates
	a_write_refused: assert property (@(posedge clk_i) disable iff (srst_i) // R18
		cur.state == PCG_ANSWER && avs_write_i && (!avs_byteenable_i[PCG_BE_LOW]
		|| !(avs_address_i == PCG_OFS_FIRST || avs_address_i == PCG_OFS_SECOND))
		|=> $stable(cur.gate_first) && $stable(cur.gate_second))
		else $error("refused write changed a gating register");
	a_status_view: assert property (@(posedge clk_i) disable iff (srst_i) // R18
		cur.state == PCG_IDLE && avs_read_i && avs_address_i == PCG_OFS_STATUS
		|=> avs_readdata_o[PCG_GATE_N-1:0] == $past(gate_on))
		else $error("status read does not show the applied enables");
	a_unmapped_err: assert property (@(posedge clk_i) disable iff (srst_i) // R18
		cur.state == PCG_IDLE && request && !mapped
		|=> avs_response_o == PCG_RESP_SLVERR && avs_readdata_o == '0)
		else $error("unmapped access not answered with an error");
	a_read_back: assert property (@(posedge clk_i) disable iff (srst_i) // R18
		cur.state == PCG_IDLE && avs_read_i && avs_address_i == PCG_OFS_SECOND
		|=> !avs_waitrequest_o && avs_readdata_o[PCG_GATE_W-1:0] == cur.gate_second)
		else $error("read back of second gating register wrong");
	a_one_wait: assert property (@(posedge clk_i) disable iff (srst_i) // R18
		cur.state == PCG_IDLE && request |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("slave did not answer on the second edge");

	// Main scenarios
	c_gate_off: cover property (@(posedge clk_i) disable iff (srst_i)
		$fell(usb_gate_o));
	c_gate_back_on: cover property (@(posedge clk_i) disable iff (srst_i)
		$rose(comparator_gate_o));
	c_status_read: cover property (@(posedge clk_i) disable iff (srst_i)
		cur.state == PCG_ANSWER && avs_read_i && avs_address_i == PCG_OFS_STATUS);
	c_unmapped: cover property (@(posedge clk_i) disable iff (srst_i)
		cur.state == PCG_ANSWER && avs_response_o == PCG_RESP_SLVERR);

endmodule // pcg_clock_gating

// [tb/pcg_periph_model.sv]
// Behavioural peripherals that only advance while their bus clock enable is high
`timescale 1ns/1ps
module pcg_periph_model (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [15:0] gate_en_i,
	output logic [15:0] activity_o
);
	// Each peripheral toggles once per enabled cycle; a stopped clock freezes it
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			activity_o <= 16'h0000;
		end else begin
			activity_o <= activity_o ^ gate_en_i;
		end
	end
endmodule // pcg_periph_model

// [tb/tb_top.sv]
// Self-checking bench for the peripheral bus clock gating block
`timescale 1ns/1ps
module tb_top;
	import pcg_pkg::*;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [PCG_ADDR_W-1:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [PCG_DATA_W-1:0] avs_writedata_i = 32'h0;
	logic [PCG_BE_W-1:0] avs_byteenable_i = 4'h0;
	logic [PCG_DATA_W-1:0] avs_readdata_o;
	logic [1:0] avs_response_o;
	logic avs_waitrequest_o;
	wire [15:0] gates;
	logic [15:0] activity;
	logic [15:0] snap;
	logic [31:0] rd;
	logic [1:0] rsp;
	logic [3:0] ofs;
	logic [7:0] pat;
	logic [15:0] want;
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;

	always #5 clk_i = ~clk_i;

	pcg_clock_gating dut_u (
		.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_response_o(avs_response_o),
		.avs_waitrequest_o(avs_waitrequest_o),
		.carrier_modulator_gate_o(gates[7]), .timer_two_gate_o(gates[6]),
		.timer_one_gate_o(gates[5]), .adc_gate_o(gates[4]), .dac_gate_o(gates[3]),
		.two_wire_bus_gate_o(gates[2]), .serial_port_two_gate_o(gates[1]),
		.serial_port_one_gate_o(gates[0]), .usb_gate_o(gates[15]),
		.delay_block_gate_o(gates[14]), .irq_pin_gate_o(gates[13]),
		.keyboard_interrupt_gate_o(gates[12]), .comparator_gate_o(gates[11]),
		.time_of_day_gate_o(gates[10]), .peripheral_serial_two_gate_o(gates[9]),
		.peripheral_serial_one_gate_o(gates[8])
	);

	pcg_periph_model periph_u (
		.clk_i(clk_i), .srst_i(srst_i), .gate_en_i(gates), .activity_o(activity)
	);

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// Request held until waitrequest is sampled low; read data taken at that edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
		input logic [3:0] be, output logic [31:0] data, output logic [1:0] resp);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= {24'h000000, d};
		avs_byteenable_i <= be;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		@(posedge clk_i);
		while (avs_waitrequest_o !== 1'b0) begin
			@(posedge clk_i);
		end
		data = avs_readdata_o;
		resp = avs_response_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask

	// Enables lag the register by one edge, so let two edges pass
	task automatic settle();
		repeat (2) @(posedge clk_i);
	endtask

	task automatic print_verdict();
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			$display("mismatch at %0t: timeout", $time);
			print_verdict();
		end
	end

	initial begin
		repeat (16) @(posedge clk_i);
		srst_i <= 1'b0;
		settle();
		check({16'h0, gates}, 32'h0000ffff, "enables after reset");
		bus(1'b0, PCG_OFS_FIRST, 8'h00, 4'hf, rd, rsp);
		check(rd, 32'h000000ff, "first reset value");
		check({30'h0, rsp}, {30'h0, PCG_RESP_OKAY}, "read resp");
		bus(1'b0, PCG_OFS_SECOND, 8'h00, 4'hf, rd, rsp);
		check(rd, 32'h000000ff, "second reset value");
		$display("test reset done");
		// Walk a single cleared bit across both registers
		for (int i = 0; i < 16; i++) begin
			ofs = (i < 8) ? PCG_OFS_FIRST : PCG_OFS_SECOND;
			pat = ~(8'h01 << (i % 8));
			want = ~(16'h0001 << i);
			bus(1'b1, ofs, pat, 4'h1, rd, rsp);
			settle();
			check({24'h0, gates[7:0]}, {24'h0, want[7:0]}, "lo");
			check({24'h0, gates[15:8]}, {24'h0, want[15:8]}, "hi");
			bus(1'b0, PCG_OFS_STATUS, 8'h00, 4'hf, rd, rsp);
			check(rd, {16'h0, want}, "status view");
			bus(1'b0, ofs, 8'h00, 4'hf, rd, rsp);
			check(rd, {24'h0, pat}, "readback");
			bus(1'b1, ofs, 8'hff, 4'h1, rd, rsp);
		end
		$display("test walking done");
		// Refused writes leave the registers alone
		bus(1'b1, PCG_OFS_FIRST, 8'h00, 4'he, rd, rsp);
		check({30'h0, rsp}, {30'h0, PCG_RESP_OKAY}, "lane0 off resp");
		bus(1'b1, PCG_OFS_STATUS, 8'h00, 4'hf, rd, rsp);
		check({30'h0, rsp}, {30'h0, PCG_RESP_OKAY}, "status write resp");
		bus(1'b0, PCG_OFS_FIRST, 8'h00, 4'hf, rd, rsp);
		check(rd, 32'h000000ff, "lane0 off ignored");
		bus(1'b0, PCG_OFS_STATUS, 8'h00, 4'hf, rd, rsp);
		check(rd, 32'h0000ffff, "status write ignored");
		bus(1'b1, 4'hc, 8'h00, 4'h1, rd, rsp);
		check({30'h0, rsp}, {30'h0, PCG_RESP_SLVERR}, "unmapped write resp");
		bus(1'b0, 4'hc, 8'h00, 4'hf, rd, rsp);
		check({30'h0, rsp}, {30'h0, PCG_RESP_SLVERR}, "unmapped resp");
		check(rd, 32'h0, "unmapped data");
		check({16'h0, gates}, 32'h0000ffff, "unmapped write ignored");
		$display("test refusal done");
		// Stopped peripherals freeze, running ones advance every cycle
		bus(1'b1, PCG_OFS_FIRST, 8'h00, 4'h1, rd, rsp);
		bus(1'b1, PCG_OFS_SECOND, 8'h00, 4'h1, rd, rsp);
		settle();
		snap = activity;
		repeat (4) @(posedge clk_i);
		check({16'h0, activity}, {16'h0, snap}, "frozen peripherals");
		bus(1'b1, PCG_OFS_FIRST, 8'ha5, 4'h1, rd, rsp);
		bus(1'b1, PCG_OFS_SECOND, 8'h5a, 4'h1, rd, rsp);
		settle();
		snap = activity;
		@(posedge clk_i);
		check({16'h0, activity ^ snap}, 32'h00005aa5, "running peripherals");
		$display("test activity done");
		print_verdict();
	end
endmodule // tb_top
